// ### bench/rgmf_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
// Board side of the reset pin: pull-up plus an external reset source
module rgmf_pin_model (
  input wire logic clk_i,
  input wire logic oe_n_i,
  input wire logic dout_i,
  output logic pin_o
);
  logic ext_low_ff = 1'b0;
  // Open-drain wire: either party pulls low, else the pull-up wins
  assign pin_o = ext_low_ff ? 1'b0 : (oe_n_i ? 1'b1 : dout_i);
  // Pulses are kept longer than phase one; the drive latched at the start holds regardless
  task automatic pulse(input int n);
    @(posedge clk_i);
    ext_low_ff <= 1'b1;
    repeat (n) @(posedge clk_i);
    ext_low_ff <= 1'b0;
  endtask : pulse
endmodule : rgmf_pin_model
`default_nettype wire

// ### bench/tb_reset_event_flag_manager.sv
`timescale 1ns/100ps
`default_nettype none
module tb_reset_event_flag_manager import rgmf_pkg::*;;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [7:0] des_evt = 8'h00, safe_req = 8'h00;
  logic safe_mode = 1'b0, stby = 1'b0;
  logic [5:0] fes_evt = 6'h00;
  logic wait_r, irq, pin, oe_n, dout, sys_rst, boot, safe_ok;
  int errors = 0, checks = 0, cyc = 0, hi, drv;
  logic [3:0] ra [5] = '{ADDR_BIDIR, ADDR_SHORT, ADDR_CFG, ADDR_MASK, 4'h8};
  logic [7:0] rx [5] = '{BIDIR_RST, SHORT_RST, CFG_RST, {5'h0, MASK_RST},
                         8'h00};

  rgmf_top dut (.CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(addr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wait_r), .IRQ_O(irq),
    .DES_EVT_I(des_evt), .FES_EVT_I(fes_evt), .SAFE_REQ_I(safe_req),
    .SAFE_MODE_I(safe_mode), .DEEP_STANDBY_I(stby), .EXT_RST_N_I(pin),
    .EXT_RST_N_O(dout), .EXT_RST_OE_N_O(oe_n), .SYS_RESET_O(sys_rst),
    .BOOT_ASSIST_O(boot), .SAFE_EXIT_OK_O(safe_ok));
  rgmf_pin_model pm (.clk_i(clk), .oe_n_i(oe_n), .dout_i(dout), .pin_o(pin));

  initial begin
    forever #10 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One access; waitrequest is sampled at each rising edge, and the
  // request drops only at the edge that saw it low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    do @(posedge clk); while (wait_r !== 1'b0);
    rv = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  // Counts cycles in the sequence and cycles with the pin driven
  task automatic run_seq(output int h, output int d);
    h = 0;
    d = 0;
    for (int i = 0; i < 400 && (h == 0 || sys_rst === 1'b1); i++) begin
      @(negedge clk);
      if (sys_rst === 1'b1) h++;
      if (oe_n === 1'b0) d++;
    end
  endtask : run_seq

  task automatic finish_test;
    if (errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test

  // A hang ends the run as a failure
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // Reset values; the unmapped place ignores a write
    bus(1'b1, 4'h8, 32'hff);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ra[i], 32'h0);
      chk("reg reset", {24'h0, rx[i]}, rv);
    end
    // Software reset, full sequence with pin driven, masked then unmasked
    bus(1'b1, ADDR_CTRL, 32'h1);
    run_seq(hi, drv);
    chk("full length", PH1_CYC + PH2_CYC + PH3_CYC, hi);
    chk("sw drive", hi, drv);
    chk("irq masked", 0, irq);
    bus(1'b1, ADDR_MASK, 32'h1);
    @(negedge clk);
    chk("irq raised", 1, irq);
    bus(1'b0, ADDR_IRQ, 32'h0);
    chk("irq status", 32'h1, rv);
    @(negedge clk);
    chk("irq cleared", 0, irq);
    // Zero leaves a flag, one clears it; read back before next sw reset
    bus(1'b1, ADDR_FES, 32'h0);
    bus(1'b0, ADDR_FES, 32'h0);
    chk("fes kept", 1, rv[1]);
    bus(1'b1, ADDR_FES, 32'h2);
    bus(1'b0, ADDR_FES, 32'h0);
    chk("fes cleared", 0, rv[1]);
    // Short reset on a drive-enabled source gives no drive
    bus(1'b1, ADDR_SHORT, 32'h2);
    bus(1'b1, ADDR_CTRL, 32'h1);
    run_seq(hi, drv);
    chk("short drive", 0, drv);
    chk("short length", PH1_CYC + PH3_CYC, hi);
    // Destructive event, then a clear cut short by a new sequence
    @(posedge clk);
    des_evt <= 8'h01;
    @(posedge clk);
    des_evt <= 8'h00;
    run_seq(hi, drv);
    chk("des drive", hi, drv);
    bus(1'b1, ADDR_DES, 32'h1);
    des_evt <= 8'h02;
    @(posedge clk);
    des_evt <= 8'h00;
    run_seq(hi, drv);
    bus(1'b0, ADDR_DES, 32'h0);
    chk("des aborted", 32'h3, rv);
    bus(1'b0, ADDR_IRQ, 32'h0);
    chk("abort irq", 32'h5, rv);
    bus(1'b1, ADDR_DES, 32'h3);
    bus(1'b0, ADDR_DES, 32'h0);
    chk("des retry", 32'h0, rv);
    // Functional event whose source has pin drive switched off
    bus(1'b1, ADDR_BIDIR, 32'h4);
    fes_evt <= 6'h01;
    @(posedge clk);
    fes_evt <= 6'h00;
    run_seq(hi, drv);
    chk("fes evt drive", 0, drv);
    chk("fes evt length", PH1_CYC + PH2_CYC + PH3_CYC, hi);
    bus(1'b0, ADDR_FES, 32'h0);
    chk("fes evt flag", 1, rv[2]);
    // External pin reset: drive kept after the pin is let go
    fork
      pm.pulse(60);
      run_seq(hi, drv);
    join
    chk("pin drive", hi, drv);
    bus(1'b0, ADDR_FES, 32'h0);
    chk("fes ext", 1, rv[0]);
    // Standby boot from RAM with flash not fully on
    bus(1'b1, ADDR_CFG, 32'h1);
    stby <= 1'b1;
    fork
      pm.pulse(60);
      run_seq(hi, drv);
    join
    @(negedge clk);
    chk("boot assist", 1, boot);
    bus(1'b0, ADDR_IRQ, 32'h0);
    chk("boot irq", 1, rv[1]);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk("status boot", 32'h2, rv);
    // Recovery by a second pulse 200 us later
    stby <= 1'b0;
    repeat (10000) @(posedge clk);
    fork
      pm.pulse(60);
      run_seq(hi, drv);
    join
    chk("boot left", 0, boot);
    // SAFE exit stays blocked while a cause is active
    @(posedge clk);
    safe_mode <= 1'b1;
    safe_req <= 8'h04;
    bus(1'b1, ADDR_FES, 32'hff);
    repeat (3) @(negedge clk);
    chk("safe blocked", 0, safe_ok);
    // Cause removed at its source, then the flag cleared
    @(posedge clk);
    safe_req <= 8'h00;
    bus(1'b1, ADDR_FES, 32'hff);
    repeat (3) @(negedge clk);
    chk("safe exit", 1, safe_ok);
    finish_test();
  end
endmodule : tb_reset_event_flag_manager
`default_nettype wire

// ### hdl/rgmf_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module rgmf_pin_sync (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic pin_i,
  output logic level_o
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic lvl_ff;

  // Three stages; level moves only once the last two agree
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
      lvl_ff <= 1'b1;
    end else begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        lvl_ff <= s3_ff;
      end
    end
  end

  assign level_o = lvl_ff;
endmodule : rgmf_pin_sync
`default_nettype wire

// ### hdl/rgmf_pkg.sv
`default_nettype none
package rgmf_pkg;
  // Word addresses on the register bus
  localparam logic [3:0] ADDR_DES = 4'h0;
  localparam logic [3:0] ADDR_FES = 4'h1;
  localparam logic [3:0] ADDR_BIDIR = 4'h2;
  localparam logic [3:0] ADDR_SHORT = 4'h3;
  localparam logic [3:0] ADDR_CFG = 4'h4;
  localparam logic [3:0] ADDR_CTRL = 4'h5;
  localparam logic [3:0] ADDR_IRQ = 4'h6;
  localparam logic [3:0] ADDR_MASK = 4'h7;
  // Reset values
  localparam logic [7:0] BIDIR_RST = 8'h00;
  localparam logic [7:0] SHORT_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h30;
  localparam logic [2:0] MASK_RST = 3'h0;
  // Field positions
  localparam int CFG_BOOT_BIT = 0;
  localparam int CFG_FLASH_LSB = 4;
  localparam logic [1:0] FLASH_FULL = 2'h3;
  localparam int CTRL_SWRST_BIT = 0;
  localparam int ST_BUSY = 0;
  localparam int ST_BAM = 1;
  localparam int ST_SAFE_OK = 2;
  localparam int ST_CLR_PEND = 3;
  localparam int IRQ_SEQ_DONE = 0;
  localparam int IRQ_BAM = 1;
  localparam int IRQ_ABORT = 2;
  localparam int FES_EXR_BIT = 0;
  localparam int FES_SW_BIT = 1;
  // Reset sequence phase lengths
  localparam int CLK_PERIOD_NS = 20;
  localparam int PH1_TIME_NS = 1000;
  localparam int PH2_TIME_NS = 2000;
  localparam int PH3_TIME_NS = 500;
  localparam logic [7:0] PH1_CYC =
    8'((PH1_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] PH2_CYC =
    8'((PH2_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] PH3_CYC =
    8'((PH3_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {ST_IDLE, ST_PH1, ST_PH2, ST_PH3} rgmf_state_t;

  // Sticky flags: a new event wins over a clear in the same cycle
  function automatic logic [7:0] rgmf_flags(input logic [7:0] cur,
                                            input logic [7:0] clr,
                                            input logic [7:0] set);
    rgmf_flags = (cur & ~clr) | set;
  endfunction : rgmf_flags
endpackage : rgmf_pkg
`default_nettype wire

// ### hdl/rgmf_top.sv
// Implementation choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
module rgmf_top import rgmf_pkg::*; (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [3:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  output logic IRQ_O,
  input wire logic [7:0] DES_EVT_I,
  input wire logic [5:0] FES_EVT_I,
  input wire logic [7:0] SAFE_REQ_I,
  input wire logic SAFE_MODE_I,
  input wire logic DEEP_STANDBY_I,
  input wire logic EXT_RST_N_I,
  output logic EXT_RST_N_O,
  output logic EXT_RST_OE_N_O,
  output logic SYS_RESET_O,
  output logic BOOT_ASSIST_O,
  output logic SAFE_EXIT_OK_O
);
  rgmf_state_t state_ff, nxt_state;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [2:0] irq_snap_ff;
  logic [7:0] des_ff, fes_ff, bidir_ff, short_ff, cfg_ff;
  logic [7:0] des_pend_ff, fes_pend_ff;
  logic [2:0] irq_ff, mask_ff;
  logic [7:0] cnt_ff, nxt_cnt;
  logic drive_ff, skip_ff, bam_cond_ff, bam_ff, busy_ff, safe_ok_ff;
  logic ext_lvl, ext_d_ff;

  // Bus handshake: one wait cycle, then the answer
  wire acc = AVS_READ_I | AVS_WRITE_I;
  wire wr_take = AVS_WRITE_I & ack_ff;
  wire rd_take = AVS_READ_I & ack_ff;
  wire rd_load = AVS_READ_I & ~ack_ff;
  wire wr_des = wr_take & (AVS_ADDRESS_I == ADDR_DES);
  wire wr_fes = wr_take & (AVS_ADDRESS_I == ADDR_FES);
  wire wr_bidir = wr_take & (AVS_ADDRESS_I == ADDR_BIDIR);
  wire wr_short = wr_take & (AVS_ADDRESS_I == ADDR_SHORT);
  wire wr_cfg = wr_take & (AVS_ADDRESS_I == ADDR_CFG);
  wire wr_mask = wr_take & (AVS_ADDRESS_I == ADDR_MASK);
  wire rd_irq = rd_take & (AVS_ADDRESS_I == ADDR_IRQ);
  wire [7:0] wdat = AVS_WRITEDATA_I[7:0];
  assign AVS_WAITREQUEST_O = acc & ~ack_ff;

  // Pin input through the filtered synchroniser
  rgmf_pin_sync u_sync (
    .CLK_I(CLK_I),
    .RST_I(RST_I),
    .pin_i(EXT_RST_N_I),
    .level_o(ext_lvl)
  );

  // Own drive pulls the pin low, so our own edge is masked out
  wire ext_fall = ext_d_ff & ~ext_lvl & ~drive_ff;
  wire sw_req = wr_take & (AVS_ADDRESS_I == ADDR_CTRL) &
                wdat[CTRL_SWRST_BIT];
  wire [7:0] fes_new = {FES_EVT_I, sw_req, ext_fall};
  wire des_any = |DES_EVT_I;
  wire trig = (state_ff == ST_IDLE) & (des_any | (|fes_new));
  // Drive-enabled (bit zero) sources drive, unless short is chosen too
  wire drive_req = des_any | (|(fes_new & ~bidir_ff & ~short_ff));
  wire skip_req = ~des_any & (&(short_ff | ~fes_new));
  wire bam_req = DEEP_STANDBY_I & fes_new[FES_EXR_BIT] &
                 cfg_ff[CFG_BOOT_BIT] &
                 (cfg_ff[CFG_FLASH_LSB +: 2] != FLASH_FULL);
  wire ph_done = (cnt_ff == 8'h01);
  wire seq_end = (state_ff == ST_PH3) & ph_done;

  // Clear waits one stage; a reset start throws it away
  wire [7:0] des_clr = des_pend_ff & ~{8{trig}};
  wire [7:0] fes_clr = fes_pend_ff & ~{8{trig}};
  wire abort = trig & ((|des_pend_ff) | (|fes_pend_ff));
  wire [2:0] irq_set = {abort, seq_end & bam_cond_ff, seq_end};
  wire [2:0] irq_clr = rd_irq ? irq_snap_ff : 3'h0;

  // Phase sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      ST_IDLE: begin
        if (trig) begin
          nxt_state = ST_PH1;
          nxt_cnt = PH1_CYC;
        end
      end
      ST_PH1: begin
        if (ph_done) begin
          nxt_state = skip_ff ? ST_PH3 : ST_PH2;
          nxt_cnt = skip_ff ? PH3_CYC : PH2_CYC;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      ST_PH2: begin
        if (ph_done) begin
          nxt_state = ST_PH3;
          nxt_cnt = PH3_CYC;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      ST_PH3: begin
        if (ph_done) begin
          nxt_state = ST_IDLE;
          nxt_cnt = 8'h00;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_cnt = 8'h00;
      end
    endcase
  end

  // Read selection
  wire [7:0] status = {4'h0, |des_pend_ff | (|fes_pend_ff), safe_ok_ff,
                       bam_ff, busy_ff};
  wire [7:0] rd_mux =
    (AVS_ADDRESS_I == ADDR_DES) ? des_ff :
    (AVS_ADDRESS_I == ADDR_FES) ? fes_ff :
    (AVS_ADDRESS_I == ADDR_BIDIR) ? bidir_ff :
    (AVS_ADDRESS_I == ADDR_SHORT) ? short_ff :
    (AVS_ADDRESS_I == ADDR_CFG) ? cfg_ff :
    (AVS_ADDRESS_I == ADDR_CTRL) ? status :
    (AVS_ADDRESS_I == ADDR_IRQ) ? {5'h00, irq_ff} :
    (AVS_ADDRESS_I == ADDR_MASK) ? {5'h00, mask_ff} : 8'h00;

  // Bus slave and software registers
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      irq_snap_ff <= 3'h0;
      bidir_ff <= BIDIR_RST;
      short_ff <= SHORT_RST;
      cfg_ff <= CFG_RST;
      mask_ff <= MASK_RST;
    end else begin
      ack_ff <= acc & ~ack_ff;
      if (rd_load) begin
        rdata_ff <= {24'h00_0000, rd_mux};
        irq_snap_ff <= irq_ff;
      end
      if (wr_bidir) bidir_ff <= wdat;
      if (wr_short) short_ff <= wdat;
      if (wr_cfg) cfg_ff <= wdat & 8'h31;
      if (wr_mask) mask_ff <= wdat[2:0];
    end
  end

  // Event flags; a one in the write data clears, zero keeps
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      des_ff <= 8'h00;
      fes_ff <= 8'h00;
      des_pend_ff <= 8'h00;
      fes_pend_ff <= 8'h00;
      irq_ff <= 3'h0;
    end else begin
      des_pend_ff <= wr_des ? wdat : 8'h00;
      fes_pend_ff <= wr_fes ? wdat : 8'h00;
      des_ff <= rgmf_flags(des_ff, des_clr, DES_EVT_I);
      fes_ff <= rgmf_flags(fes_ff, fes_clr, fes_new);
      irq_ff <= (irq_ff & ~irq_clr) | irq_set;
    end
  end

  // Sequencer state, pin drive and boot-assist latch
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 8'h00;
      drive_ff <= 1'b0;
      skip_ff <= 1'b0;
      bam_cond_ff <= 1'b0;
      bam_ff <= 1'b0;
      busy_ff <= 1'b0;
      ext_d_ff <= 1'b1;
      safe_ok_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      ext_d_ff <= ext_lvl;
      // Exit only while no cause is active, whatever the flags say
      safe_ok_ff <= SAFE_MODE_I & ~(|SAFE_REQ_I);
      if (trig) begin
        // Drive latched here holds to the end, even if the pin lets go
        drive_ff <= drive_req;
        skip_ff <= skip_req;
        bam_cond_ff <= bam_req;
        bam_ff <= 1'b0;
        busy_ff <= 1'b1;
      end else if (seq_end) begin
        drive_ff <= 1'b0;
        bam_ff <= bam_cond_ff;
        busy_ff <= 1'b0;
      end
    end
  end

  assign AVS_READDATA_O = rdata_ff;
  assign IRQ_O = |(irq_ff & mask_ff);
  assign EXT_RST_N_O = 1'b0;
  assign EXT_RST_OE_N_O = ~drive_ff;
  assign SYS_RESET_O = busy_ff;
  assign BOOT_ASSIST_O = bam_ff;
  assign SAFE_EXIT_OK_O = safe_ok_ff;

  sequence s_des_clr;
    wr_des ##1 !trig;
  endsequence
  property p_clr_two;
    @(posedge CLK_I) disable iff (RST_I)
    s_des_clr |=> ((des_ff & $past(wdat, 2) & ~$past(DES_EVT_I)) == 8'h00);
  endproperty
  a_clr_two: assert property (p_clr_two)
    else $error("flag clear did not complete in two cycles");
  property p_abort;
    @(posedge CLK_I) disable iff (RST_I)
    (trig && (|des_pend_ff)) |=> irq_ff[IRQ_ABORT] && des_pend_ff == 8'h00;
  endproperty
  a_abort: assert property (p_abort)
    else $error("reset did not abort pending clear");
  property p_w1c_zero;
    @(posedge CLK_I) disable iff (RST_I)
    (wr_fes && wdat == 8'h00) |=> fes_pend_ff == 8'h00;
  endproperty
  a_w1c_zero: assert property (p_w1c_zero)
    else $error("zero write started a clear");
  property p_short_nodrive;
    @(posedge CLK_I) disable iff (RST_I)
    (trig && !des_any && !(|(fes_new & ~bidir_ff & ~short_ff))) |=> !drive_ff;
  endproperty
  a_short_nodrive: assert property (p_short_nodrive)
    else $error("short reset source drove the pin");
  sequence s_ext_start;
    trig && ext_fall && !bidir_ff[FES_EXR_BIT] && !short_ff[FES_EXR_BIT];
  endsequence
  property p_drive_hold;
    @(posedge CLK_I) disable iff (RST_I)
    s_ext_start |=> (!EXT_RST_OE_N_O && state_ff == ST_PH1)[*8];
  endproperty
  a_drive_hold: assert property (p_drive_hold)
    else $error("external reset not driven in phase one");
  property p_drive_in_seq;
    @(posedge CLK_I) disable iff (RST_I)
    !EXT_RST_OE_N_O |-> state_ff != ST_IDLE && SYS_RESET_O;
  endproperty
  a_drive_in_seq: assert property (p_drive_in_seq)
    else $error("pin driven outside reset sequence");
  property p_bam;
    @(posedge CLK_I) disable iff (RST_I)
    (seq_end && bam_cond_ff) |=> BOOT_ASSIST_O && !SYS_RESET_O;
  endproperty
  a_bam: assert property (p_bam)
    else $error("boot assist state not entered");
  property p_bam_hold;
    @(posedge CLK_I) disable iff (RST_I)
    (BOOT_ASSIST_O && !trig) |=> BOOT_ASSIST_O;
  endproperty
  a_bam_hold: assert property (p_bam_hold)
    else $error("boot assist state left without reset");
  property p_safe;
    @(posedge CLK_I) disable iff (RST_I)
    (|SAFE_REQ_I) |=> !SAFE_EXIT_OK_O;
  endproperty
  a_safe: assert property (p_safe)
    else $error("safe exit allowed with cause active");
endmodule : rgmf_top
`default_nettype wire
